/* rtl/bbs_pkg.sv */
package bbs_pkg;

    // ----------------------------------------
    // register map (ahb-lite byte offsets)
    // ----------------------------------------
    localparam logic [11:0] BBS_CFG_OFF    = 12'h000;
    localparam logic [11:0] BBS_PORT0_OFF  = 12'h004;
    localparam logic [11:0] BBS_PORT1_OFF  = 12'h008;
    localparam logic [11:0] BBS_PORT2_OFF  = 12'h00C;
    localparam logic [11:0] BBS_STAT_OFF   = 12'h010;
    localparam logic [1:0]  BBS_WIN_SEL    = 2'h1;

    // ----------------------------------------
    // config fields
    // ----------------------------------------
    localparam int BBS_CFG_MODE_LSB  = 0;
    localparam int BBS_CFG_BANKEN    = 4;
    localparam int BBS_CFG_BANKVAL   = 5;
    localparam logic [7:0] BBS_PORT2_RST = 8'hFF;

    typedef enum logic [1:0] {
        MODE_SW_READ,
        MODE_SW_WRITE,
        MODE_FAST,
        MODE_MMAP
    } bbs_mode_t;

    // ----------------------------------------
    // control port bits and values
    // ----------------------------------------
    localparam int BBS_CTL_RD   = 2;
    localparam int BBS_CTL_WR   = 1;
    localparam int BBS_CTL_BANK = 0;
    localparam logic [7:0] BBS_CTL_OE_SW = 8'h0F;
    localparam logic [7:0] BBS_CTL_OE_HW = 8'h07;
    localparam logic [4:0] BBS_CTL_HS_IDLE = 5'h1F;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int BBS_CLK_NS     = 8;
    localparam int BBS_GAP_NS     = 850;
    localparam int BBS_GAP_CYC    = (BBS_GAP_NS + BBS_CLK_NS - 1) / BBS_CLK_NS;
    localparam int BBS_SETUP_CYC  = 2;
    localparam int BBS_STROBE_CYC = 4;
    localparam int BBS_HOLD_CYC   = 2;

    // ----------------------------------------
    // peripheral module
    // ----------------------------------------
    localparam logic [3:0] BBS_ID_REG = 4'hF;

endpackage

/* rtl/bbs_bus_if.sv */
`timescale 1ns/1ps
interface bbs_bus_if;
    logic [7:0] m_data;
    logic       m_data_oe;
    logic [7:0] p_data;
    logic       p_data_oe;
    logic [7:0] addr;
    logic [7:0] ctl;
    logic [7:0] ctl_oe;
    logic [1:0] irq;
    logic       bus_rst;
    wire  [7:0] data_line;
    wire  [7:0] ctl_line;

    // pulled-up lines: undriven bits read high
    assign data_line = m_data_oe ? m_data : (p_data_oe ? p_data : 8'hFF);
    assign ctl_line  = (ctl & ctl_oe) | ~ctl_oe;

    modport master (output m_data, m_data_oe, addr, ctl, ctl_oe, bus_rst, input data_line, irq);
    modport module_end (output p_data, p_data_oe, irq, input data_line, addr, ctl_line, bus_rst);
endinterface

/* rtl/bbs_periph.sv */
`timescale 1ns/1ps
module bbs_periph
    import bbs_pkg::*;
#(
    parameter logic [3:0] CARD_ID  = 4'h1,
    parameter int         IRQ_LINE = 0
)(
    input  wire logic       clk,
    input  wire logic       srst,
    bbs_bus_if.module_end   bus,
    input  wire logic [7:0] usr_irq_src,
    output logic            usr_wr_stb,
    output logic [3:0]      usr_wr_idx,
    output logic [7:0]      usr_wr_data
);

    if (IRQ_LINE < 0 || IRQ_LINE > 1) begin : g_chk
        $error("IRQ_LINE must be 0 or 1");
    end

    typedef struct packed {
        logic [14:0][7:0] regs;
        logic             wr_act;
        logic [3:0]       wr_idx;
        logic [7:0]       wr_data;
        logic [7:0]       dout;
        logic             dout_oe;
        logic [1:0]       irq;
        logic             stb;
        logic [3:0]       stb_idx;
        logic [7:0]       stb_data;
    } bbs_pst_t;

    bbs_pst_t q;
    bbs_pst_t d;
    logic     sel;
    logic [7:0] id_val;

    always_comb
    begin
        d = q;
        d.stb = 1'b0;
        sel = bus.ctl_line[BBS_CTL_BANK] && (bus.addr[7:4] == CARD_ID);
        // ----------------------------------------
        // interrupt identification
        // ----------------------------------------
        id_val = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (usr_irq_src[i])
            begin
                id_val = {1'b1, 4'h0, 3'(i)};
            end
        end
        d.irq = 2'b00;
        d.irq[IRQ_LINE] = |usr_irq_src;
        // ----------------------------------------
        // read: drive data while strobe is low
        // ----------------------------------------
        d.dout_oe = sel && !bus.ctl_line[BBS_CTL_RD];
        if (bus.addr[3:0] == BBS_ID_REG)
        begin
            d.dout = id_val;
        end
        else
        begin
            d.dout = q.regs[bus.addr[3:0]];
        end
        // ----------------------------------------
        // write: capture while low, commit on release
        // ----------------------------------------
        // bank may fall with the release, so selection is judged while low
        if (sel && !bus.ctl_line[BBS_CTL_WR])
        begin
            d.wr_act = 1'b1;
            d.wr_idx = bus.addr[3:0];
            d.wr_data = bus.data_line;
        end
        else if (q.wr_act && bus.ctl_line[BBS_CTL_WR])
        begin
            d.wr_act = 1'b0;
            if (q.wr_idx != BBS_ID_REG)
            begin
                d.regs[q.wr_idx] = q.wr_data;
                d.stb = 1'b1;
                d.stb_idx = q.wr_idx;
                d.stb_data = q.wr_data;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || bus.bus_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign bus.p_data    = q.dout;
    assign bus.p_data_oe = q.dout_oe;
    assign bus.irq       = q.irq;
    assign usr_wr_stb    = q.stb;
    assign usr_wr_idx    = q.stb_idx;
    assign usr_wr_data   = q.stb_data;

endmodule

/* rtl/bbs_master.sv */
`timescale 1ns/1ps
module bbs_master
    import bbs_pkg::*;
#(
    parameter int SETUP_CYC  = BBS_SETUP_CYC,
    parameter int STROBE_CYC = BBS_STROBE_CYC,
    parameter int HOLD_CYC   = BBS_HOLD_CYC,
    parameter int GAP_CYC    = BBS_GAP_CYC
)(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             handshake_interrupt_out,
    output logic [1:0]       irq_sync,
    bbs_bus_if.master        bus
);

    if (SETUP_CYC < 0 || SETUP_CYC > 255 || STROBE_CYC < 1 || STROBE_CYC > 255
        || HOLD_CYC < 0 || HOLD_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255) begin : g_chk
        $error("timing counts must fit 8 bits");
    end

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_SETUP,
        SQ_STROBE,
        SQ_HOLD
    } bbs_sq_t;

    typedef struct packed {
        bbs_mode_t   mode;
        logic        bank_en;
        logic        bank_val;
        logic [7:0]  port0;
        logic [7:0]  port1;
        logic [7:0]  port2;
        logic        ap_valid;
        logic        ap_write;
        logic [11:0] ap_addr;
        logic        hready;
        logic [31:0] hrdata;
        bbs_sq_t     sq;
        logic        seq_rd;
        logic [7:0]  seq_addr;
        logic [7:0]  cnt;
        logic [7:0]  gap;
        logic [7:0]  dout;
        logic        dout_oe;
        logic [7:0]  aout;
        logic [7:0]  ctl;
        logic [7:0]  ctl_oe;
        logic [1:0]  irq_s1;
        logic [1:0]  irq_s2;
        logic        hs_int;
        logic        bus_rst;
    } bbs_mst_t;

    bbs_mst_t q;
    bbs_mst_t d;
    logic     sw_mode;
    logic     win;
    logic     go;

    always_comb
    begin
        d = q;
        go = 1'b0;
        sw_mode = (q.mode == MODE_SW_READ) || (q.mode == MODE_SW_WRITE);
        win = (q.ap_addr[11:10] == BBS_WIN_SEL) && (q.mode == MODE_MMAP);
        d.bus_rst = 1'b0;
        // ----------------------------------------
        // interrupt line synchroniser
        // ----------------------------------------
        d.irq_s1 = bus.irq;
        d.irq_s2 = q.irq_s1;
        if (q.gap != 8'h00)
        begin
            d.gap = q.gap - 8'h01;
        end
        // ----------------------------------------
        // ahb-lite address phase: one wait state minimum
        // ----------------------------------------
        if (hsel && htrans[1] && hready && q.hready)
        begin
            d.ap_valid = 1'b1;
            d.ap_write = hwrite;
            d.ap_addr = haddr[11:0];
            d.hready = 1'b0;
        end
        // ----------------------------------------
        // ahb-lite data phase
        // ----------------------------------------
        if (q.ap_valid)
        begin
            d.ap_valid = 1'b0;
            d.hready = 1'b1;
            d.hrdata = 32'h0000_0000;
            if (win)
            begin
                go = 1'b1;
                d.seq_addr = q.ap_addr[9:2];
                if (q.ap_write)
                begin
                    d.port0 = hwdata[7:0];
                end
            end
            else if (q.ap_write)
            begin
                unique case (q.ap_addr)
                    BBS_CFG_OFF:
                    begin
                        d.mode = bbs_mode_t'(hwdata[BBS_CFG_MODE_LSB +: 2]);
                        d.bank_en = hwdata[BBS_CFG_BANKEN];
                        d.bank_val = hwdata[BBS_CFG_BANKVAL];
                    end
                    BBS_PORT0_OFF:
                    begin
                        d.port0 = hwdata[7:0];
                        if (q.mode == MODE_FAST)
                        begin
                            go = 1'b1;
                            d.seq_addr = q.port1;
                        end
                    end
                    BBS_PORT1_OFF:
                    begin
                        // address frozen while a software strobe is low
                        if (!(sw_mode && !(q.port2[BBS_CTL_RD] && q.port2[BBS_CTL_WR])))
                        begin
                            d.port1 = hwdata[7:0];
                        end
                    end
                    BBS_PORT2_OFF: d.port2 = hwdata[7:0];
                    default:;
                endcase
            end
            else
            begin
                unique case (q.ap_addr)
                    BBS_CFG_OFF: d.hrdata = {26'h0, q.bank_val, q.bank_en, 2'h0, 2'(q.mode)};
                    BBS_PORT0_OFF:
                    begin
                        d.hrdata = {24'h0, bus.data_line};
                        if (q.mode == MODE_FAST)
                        begin
                            go = 1'b1;
                            d.seq_addr = q.port1;
                        end
                    end
                    BBS_PORT1_OFF: d.hrdata = {24'h0, q.port1};
                    BBS_PORT2_OFF: d.hrdata = {24'h0, q.port2};
                    BBS_STAT_OFF: d.hrdata = {27'h0, q.irq_s2, q.hs_int, q.gap != 8'h00, q.sq != SQ_IDLE};
                    default:;
                endcase
            end
            if (go)
            begin
                d.hready = 1'b0;
                d.seq_rd = !q.ap_write;
                d.sq = SQ_SETUP;
                d.cnt = 8'(SETUP_CYC);
            end
        end
        // ----------------------------------------
        // hardware strobe sequencer
        // ----------------------------------------
        unique case (q.sq)
            SQ_IDLE:;
            SQ_SETUP:
            begin
                if (q.cnt != 8'h00)
                begin
                    d.cnt = q.cnt - 8'h01;
                end
                else if (q.gap == 8'h00)
                begin
                    d.sq = SQ_STROBE;
                    d.cnt = 8'(STROBE_CYC - 1);
                    d.gap = 8'(GAP_CYC - 1);
                end
            end
            SQ_STROBE:
            begin
                if (q.cnt != 8'h00)
                begin
                    d.cnt = q.cnt - 8'h01;
                end
                else
                begin
                    d.sq = SQ_HOLD;
                    d.cnt = 8'(HOLD_CYC);
                    if (q.seq_rd)
                    begin
                        d.hrdata = {24'h0, bus.data_line};
                    end
                end
            end
            SQ_HOLD:
            begin
                if (q.cnt != 8'h00)
                begin
                    d.cnt = q.cnt - 8'h01;
                end
                else
                begin
                    d.sq = SQ_IDLE;
                    d.hready = 1'b1;
                end
            end
        endcase
        // ----------------------------------------
        // bus pin drive, registered from next state
        // ----------------------------------------
        if (d.mode == MODE_SW_READ || d.mode == MODE_SW_WRITE)
        begin
            d.ctl = d.port2;
            d.ctl_oe = BBS_CTL_OE_SW;
            d.dout_oe = (d.mode == MODE_SW_WRITE);
            d.aout = d.port1;
        end
        else
        begin
            d.ctl_oe = BBS_CTL_OE_HW;
            d.ctl = {BBS_CTL_HS_IDLE,
                     !(d.sq == SQ_STROBE && d.seq_rd),
                     !(d.sq == SQ_STROBE && !d.seq_rd),
                     d.bank_en ? (d.sq != SQ_IDLE) : d.bank_val};
            d.dout_oe = (d.sq != SQ_IDLE) && !d.seq_rd;
            d.aout = (d.sq != SQ_IDLE) ? d.seq_addr : d.port1;
        end
        d.dout = d.port0;
        d.hs_int = (d.mode == MODE_FAST) && (d.sq == SQ_IDLE) && (d.gap == 8'h00);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.hready <= 1'b1;
            q.port2 <= BBS_PORT2_RST;
            q.ctl <= BBS_PORT2_RST;
            q.ctl_oe <= BBS_CTL_OE_SW;
            q.bus_rst <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign hreadyout               = q.hready;
    assign hrdata                  = q.hrdata;
    assign hresp                   = q.bus_rst & 1'b0;
    assign handshake_interrupt_out = q.hs_int;
    assign irq_sync                = q.irq_s2;
    assign bus.m_data              = q.dout;
    assign bus.m_data_oe           = q.dout_oe;
    assign bus.addr                = q.aout;
    assign bus.ctl                 = q.ctl;
    assign bus.ctl_oe              = q.ctl_oe;
    assign bus.bus_rst             = q.bus_rst;

endmodule

/* tb/bbs_chk.sv */
`timescale 1ns/1ps
module bbs_chk
    import bbs_pkg::*;
#(
    parameter int         GAP_CYC = BBS_GAP_CYC,
    parameter logic [3:0] CARD_ID = 4'h1
)(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       m_data_oe,
    input wire logic       p_data_oe,
    input wire logic [7:0] addr,
    input wire logic [7:0] ctl_oe,
    input wire logic [7:0] ctl_line
);
    // ----------------------------------------
    // helper: cycles since last hardware strobe
    // ----------------------------------------
    logic       strb;
    logic       strb_q;
    logic       hw_start;
    logic [7:0] gap_q;
    logic [7:0] gap_d;

    assign strb     = !ctl_line[BBS_CTL_RD] || !ctl_line[BBS_CTL_WR];
    assign hw_start = strb && !strb_q && (ctl_oe == BBS_CTL_OE_HW);
    // saturates so the first strobe after reset always passes
    always_comb gap_d = hw_start ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gap_q  <= 8'hFF;
            strb_q <= 1'b0;
        end
        else
        begin
            gap_q  <= gap_d;
            strb_q <= strb;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_wr_pulse;
        (!ctl_line[BBS_CTL_WR]) [*4] ##1 ctl_line[BBS_CTL_WR];
    endsequence
    sequence s_rd_pulse;
        (!ctl_line[BBS_CTL_RD]) [*4] ##1 ctl_line[BBS_CTL_RD];
    endsequence

    a_ctl_dir_ok: assert property (ctl_oe == BBS_CTL_OE_SW || ctl_oe == BBS_CTL_OE_HW)
        else $error("control direction wrong");
    a_wr_pulse_len: assert property ($fell(ctl_line[BBS_CTL_WR]) && ctl_oe == BBS_CTL_OE_HW |-> s_wr_pulse)
        else $error("write strobe length wrong");
    a_rd_pulse_len: assert property ($fell(ctl_line[BBS_CTL_RD]) && ctl_oe == BBS_CTL_OE_HW |-> s_rd_pulse)
        else $error("read strobe length wrong");
    a_strobe_gap_min: assert property (hw_start |-> gap_q >= GAP_CYC - 1)
        else $error("strobes too close");
    a_addr_bank_hold: assert property (strb && strb_q |-> $stable(addr) && $stable(ctl_line[0]))
        else $error("address moved during strobe");
    a_bank_en_high: assert property (strb |-> ctl_line[BBS_CTL_BANK])
        else $error("bank low during strobe");
    a_rd_release: assert property (!ctl_line[BBS_CTL_RD] |-> !m_data_oe)
        else $error("master drives data in read");
    a_wr_drive: assert property (!ctl_line[BBS_CTL_WR] |-> m_data_oe)
        else $error("master idle in write");
    a_one_driver: assert property (!(m_data_oe && p_data_oe))
        else $error("data path contention");
    a_periph_answer: assert property ($fell(ctl_line[BBS_CTL_RD]) && ctl_line[0] && addr[7:4] == CARD_ID
        |=> p_data_oe)
        else $error("module did not answer read");
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import bbs_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  usr_irq_src = 8'h00;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        hs_int;
    logic [1:0]  irq_sync;
    logic        usr_wr_stb;
    logic [3:0]  usr_wr_idx;
    logic [7:0]  usr_wr_data;
    logic [31:0] rd_q[$];
    logic [11:0] wr_q[$];
    logic        rd_ph = 1'b0;
    logic [7:0]  mem[16];
    logic [3:0]  ixs[3];
    logic [7:0]  d;
    logic [2:0]  hb;
    int          err_count = 0;
    int          compares = 0;
    int          seed = 32'hc7810d1a;
    int          rv;

    bbs_bus_if i_bbs_bus_if();
    bbs_master #(.GAP_CYC(8)) i_bbs_master (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .handshake_interrupt_out(hs_int),
        .irq_sync(irq_sync), .bus(i_bbs_bus_if));
    bbs_periph #(.CARD_ID(4'h1), .IRQ_LINE(0)) i_bbs_periph (.clk(clk), .srst(srst), .bus(i_bbs_bus_if),
        .usr_irq_src(usr_irq_src), .usr_wr_stb(usr_wr_stb), .usr_wr_idx(usr_wr_idx), .usr_wr_data(usr_wr_data));
    bbs_chk #(.GAP_CYC(8), .CARD_ID(4'h1)) i_bbs_chk (.clk(clk), .srst(srst),
        .m_data_oe(i_bbs_bus_if.m_data_oe), .p_data_oe(i_bbs_bus_if.p_data_oe), .addr(i_bbs_bus_if.addr),
        .ctl_oe(i_bbs_bus_if.ctl_oe), .ctl_line(i_bbs_bus_if.ctl_line));

    always #4 clk = ~clk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // waits are unbounded here; the watchdog cuts a hang
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask
    task automatic w(input logic [11:0] a, input logic [7:0] v);
        xfer(1'b1, a, {24'h0, v});
    endtask
    task automatic r(input logic [11:0] a, input logic [7:0] e);
        rd_q.push_back({24'h0, e});
        xfer(1'b0, a, 32'h0);
    endtask
    // irq sources only move between sequences, never inside one
    task automatic sw_rd(input logic [7:0] adr, input logic [7:0] e);
        w(BBS_PORT2_OFF, 8'hFF);
        w(BBS_PORT1_OFF, adr);
        w(BBS_PORT2_OFF, 8'hFB);
        r(BBS_PORT0_OFF, e);
        w(BBS_PORT2_OFF, 8'hFE);
    endtask

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (rd_ph && hreadyout === 1'b1)
        begin
            chk32("hrdata", rd_q.pop_front(), hrdata);
            chk32("hresp", 32'h0, {31'h0, hresp});
        end
        if (usr_wr_stb === 1'b1)
            chk32("usr_wr", {20'h0, wr_q.pop_front()}, {20'h0, usr_wr_idx, usr_wr_data});
        if (hreadyout === 1'b1)
            rd_ph <= hsel && htrans[1] && !hwrite;
    end

    initial
    begin
        #400000;
        err_count++;
        report_and_stop;
    end

    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        r(BBS_CFG_OFF, 8'h00);
        r(BBS_PORT2_OFF, BBS_PORT2_RST);
        r(12'h020, 8'h00);
        chk32("ctl_line", 32'hFF, {24'h0, i_bbs_bus_if.ctl_line});
        $display("test reset done");
        w(BBS_CFG_OFF, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            rv = $random(seed);
            ixs[k] = (rv[3:0] == 4'hF) ? 4'h0 : rv[3:0];
            d = rv[15:8];
            mem[ixs[k]] = d;
            w(BBS_PORT2_OFF, 8'hFF);
            w(BBS_PORT1_OFF, {4'h1, ixs[k]});
            w(BBS_PORT0_OFF, d);
            w(BBS_PORT2_OFF, 8'hFD);
            chk32("ctl_line", 32'hFD, {24'h0, i_bbs_bus_if.ctl_line});
            w(BBS_PORT1_OFF, 8'h2F);
            chk32("addr", {24'h0, 4'h1, ixs[k]}, {24'h0, i_bbs_bus_if.addr});
            wr_q.push_back({ixs[k], d});
            w(BBS_PORT2_OFF, 8'hFE);
        end
        $display("test software write done");
        w(BBS_CFG_OFF, 8'h00);
        chk32("hs_int", 32'h0, {31'h0, hs_int});
        for (int k = 0; k < 3; k++)
            sw_rd({4'h1, ixs[k]}, mem[ixs[k]]);
        rv = $random(seed);
        usr_irq_src <= rv[7:0] | 8'h01;
        hb = 3'h0;
        for (int b = 0; b < 8; b++)
            if (rv[b] || b == 0)
                hb = b[2:0];
        repeat (4) @(posedge clk);
        chk32("irq_sync", 32'h1, {30'h0, irq_sync});
        sw_rd({4'h1, BBS_ID_REG}, {1'b1, 4'h0, hb});
        sw_rd({4'h2, ixs[0]}, 8'hFF);
        usr_irq_src <= 8'h00;
        repeat (4) @(posedge clk);
        chk32("irq_sync", 32'h0, {30'h0, irq_sync});
        $display("test software read done");
        w(BBS_CFG_OFF, 8'h12);
        w(BBS_PORT1_OFF, {4'h1, ixs[1]});
        chk32("hs_int", 32'h1, {31'h0, hs_int});
        for (int k = 0; k < 2; k++)
        begin
            rv = $random(seed);
            wr_q.push_back({ixs[1], rv[7:0]});
            w(BBS_PORT0_OFF, rv[7:0]);
        end
        r(BBS_PORT0_OFF, rv[7:0]);
        chk32("ctl_line", 32'hFE, {24'h0, i_bbs_bus_if.ctl_line});
        $display("test fast bus done");
        w(BBS_CFG_OFF, 8'h13);
        rv = $random(seed);
        wr_q.push_back({ixs[2], rv[7:0]});
        w({2'b01, 4'h1, ixs[2], 2'b00}, rv[7:0]);
        r({2'b01, 4'h1, ixs[2], 2'b00}, rv[7:0]);
        w(BBS_CFG_OFF, 8'h23);
        r({2'b01, 4'h1, ixs[2], 2'b00}, rv[7:0]);
        chk32("ctl_line", 32'hFF, {24'h0, i_bbs_bus_if.ctl_line});
        repeat (4) @(posedge clk);
        $display("test mapped done");
        chk32("queues", 32'h0, wr_q.size() + rd_q.size());
        report_and_stop;
    end
endmodule
